// ### shared/asrc_pkg.sv
// Package: constants and types for the asynchronous SRAM host controller
package asrc_pkg;

  // ***************************************************************
  // Array shape
  // ***************************************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 9;

  // ***************************************************************
  // Timing (ns as printed, cycles derived from the 50 MHz clock)
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CYCLE_MIN_NS = 12;
  localparam int T_ACCESS_MAX_NS = 12;
  localparam int T_WPULSE_MIN_NS = 10;
  localparam int T_DSETUP_MIN_NS = 6;
  localparam int T_RECOVER_MIN_NS = 7;
  localparam int RD_WAIT_CYC =
    (T_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WR_PULSE_CYC =
    (T_WPULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC =
    (T_RECOVER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_RD,
    ASRC_WR_SETUP,
    ASRC_WR_PULSE,
    ASRC_WR_END,
    ASRC_RECOVER
  } asrc_state_t;

endpackage : asrc_pkg

// ### shared/asrc_cnt_if.sv
// Interface: load and done between the controller and its cycle timer
interface asrc_cnt_if;
  import asrc_pkg::*;
  logic             load;
  logic [CNT_W-1:0] value;
  logic             done;
  modport ctrl  (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface : asrc_cnt_if

// ### design/asrc_timer.sv
// Down counter that times the read wait, write pulse and recovery phases of a memory cycle
module asrc_timer (
  input  wire logic clock_in,
  input  wire logic arst_n_in,
  asrc_cnt_if.timer cnt
);
  import asrc_pkg::*;

  logic [CNT_W-1:0] count_q;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_q <= '0;
    end else if (cnt.load) begin
      count_q <= cnt.value;
    end else if (count_q != '0) begin
      count_q <= count_q - 4'h1;
    end
  end

  // Done looks at the count alone: the sequencer derives load from done,
  // so feeding load back here would close a combinational loop
  assign cnt.done = (count_q == '0);

endmodule // asrc_timer

// ### design/asrc_host.sv
// Host controller that drives a 32K-word asynchronous static RAM
module asrc_host (
  input  wire logic                          clock_in,
  input  wire logic                          arst_n_in,
  input  wire logic                          req_valid_in,
  input  wire logic                          req_write_in,
  input  wire logic [asrc_pkg::ADDR_W-1:0]   req_addr_in,
  input  wire logic [asrc_pkg::DATA_W-1:0]   req_wdata_in,
  output logic                               req_ready_out,
  output logic                               rsp_valid_out,
  output logic [asrc_pkg::DATA_W-1:0]        rsp_rdata_out,
  output logic [asrc_pkg::ADDR_W-1:0]        word_index_lines_out,
  output logic                               primary_select_n_out,
  output logic                               secondary_select_hi_out,
  output logic                               out_gate_n_out,
  output logic                               write_strobe_n_out,
  input  wire logic [asrc_pkg::DATA_W-1:0]   bidir_data_pins_in,
  output logic [asrc_pkg::DATA_W-1:0]        bidir_data_pins_out,
  output logic                               bidir_data_pins_oe_n_out
);
  import asrc_pkg::*;

  // ***************************************************************
  // State and pin registers
  // ***************************************************************
  asrc_state_t       state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic              sel_n_q;
  logic              gate_n_q;
  logic              wr_n_q;
  logic              drive_q;
  logic              rsp_q;
  logic [DATA_W-1:0] din_s1_q;
  logic [DATA_W-1:0] din_s2_q;
  logic              take;

  asrc_cnt_if cnt ();

  asrc_timer u_timer (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .cnt       (cnt)
  );

  // ***************************************************************
  // Request handshake
  // ***************************************************************
  assign req_ready_out = (state_q == ASRC_IDLE);
  assign take          = req_valid_in && req_ready_out;

  // ***************************************************************
  // Read data synchroniser
  // ***************************************************************
  // Pins are not timed against our clock, so two flops before use
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      din_s1_q <= bidir_data_pins_in;
      din_s2_q <= din_s1_q;
    end
  end

  // ***************************************************************
  // Cycle sequencer
  // ***************************************************************
  always_comb begin
    cnt.load  = 1'b0;
    cnt.value = '0;
    unique case (state_q)
      ASRC_IDLE: begin
        if (take) begin
          cnt.load  = 1'b1;
          cnt.value = req_write_in ? CNT_W'(1) : CNT_W'(RD_WAIT_CYC);
        end
      end
      ASRC_WR_SETUP: begin
        cnt.load  = 1'b1;
        cnt.value = CNT_W'(WR_PULSE_CYC);
      end
      ASRC_RD, ASRC_WR_END: begin
        if (cnt.done) begin
          cnt.load  = 1'b1;
          cnt.value = CNT_W'(RECOVER_CYC);
        end
      end
      ASRC_WR_PULSE, ASRC_RECOVER: begin
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ASRC_IDLE;
    end else begin
      unique case (state_q)
        ASRC_IDLE: begin
          if (take) begin
            state_q <= req_write_in ? ASRC_WR_SETUP : ASRC_RD;
          end
        end
        ASRC_RD: begin
          if (cnt.done) begin
            state_q <= ASRC_RECOVER;
          end
        end
        ASRC_WR_SETUP: state_q <= ASRC_WR_PULSE;
        ASRC_WR_PULSE: begin
          if (cnt.done) begin
            state_q <= ASRC_WR_END;
          end
        end
        ASRC_WR_END: begin
          if (cnt.done) begin
            state_q <= ASRC_RECOVER;
          end
        end
        ASRC_RECOVER: begin
          if (cnt.done) begin
            state_q <= ASRC_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // Address and write data
  // ***************************************************************
  // Address is latched at take and held until the next take, so it
  // changes on the same edge that select falls and is stable for the whole cycle
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (take) begin
      addr_q  <= req_addr_in;
      if (req_write_in) begin
        wdata_q <= req_wdata_in;
      end
    end
  end

  // ***************************************************************
  // Control pins
  // ***************************************************************
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_n_q  <= 1'b1;
      gate_n_q <= 1'b1;
      wr_n_q   <= 1'b1;
      drive_q  <= 1'b0;
    end else begin
      unique case (state_q)
        ASRC_IDLE: begin
          sel_n_q  <= !(take);
          gate_n_q <= !(take && !req_write_in);
          wr_n_q   <= 1'b1;
          drive_q  <= take && req_write_in;
        end
        ASRC_WR_SETUP: begin
          wr_n_q <= 1'b0;
        end
        ASRC_WR_PULSE: begin
          // Strobe rises first; data held one more cycle as hold time
          if (cnt.done) begin
            wr_n_q <= 1'b1;
          end
        end
        ASRC_WR_END: begin
          sel_n_q <= 1'b1;
          drive_q <= 1'b0;
        end
        ASRC_RD: begin
          if (cnt.done) begin
            sel_n_q  <= 1'b1;
            gate_n_q <= 1'b1;
          end
        end
        ASRC_RECOVER: begin
        end
      endcase
    end
  end

  // ***************************************************************
  // Read response
  // ***************************************************************
  // Sampling through the synchroniser costs two cycles; the read
  // wait count already covers the access time plus that latency
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= (state_q == ASRC_RD) && cnt.done;
      if ((state_q == ASRC_RD) && cnt.done) begin
        rdata_q <= din_s2_q;
      end
    end
  end

  assign word_index_lines_out     = addr_q;
  assign primary_select_n_out     = sel_n_q;
  assign secondary_select_hi_out  = !sel_n_q;
  assign out_gate_n_out           = gate_n_q;
  assign write_strobe_n_out       = wr_n_q;
  assign bidir_data_pins_out      = wdata_q;
  assign bidir_data_pins_oe_n_out = !drive_q;
  assign rsp_valid_out            = rsp_q;
  assign rsp_rdata_out            = rdata_q;

endmodule // asrc_host

// ### verif/asrc_host_checker.sv
// Checker: host-side protocol checks on the memory pins
module asrc_host_checker
  import asrc_pkg::*;
(
  input wire logic              clock_in,
  input wire logic              arst_n_in,
  input wire logic              req_valid_in,
  input wire logic              req_write_in,
  input wire logic              req_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic [ADDR_W-1:0] word_index_lines_out,
  input wire logic              primary_select_n_out,
  input wire logic              secondary_select_hi_out,
  input wire logic              out_gate_n_out,
  input wire logic              write_strobe_n_out,
  input wire logic              bidir_data_pins_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire sn = primary_select_n_out;
  wire gn = out_gate_n_out;
  wire wn = write_strobe_n_out;
  wire on = bidir_data_pins_oe_n_out;
  wire tk = req_valid_in && req_ready_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // ***************************************************************
  // Cycle shapes
  // ***************************************************************
  sequence s_rd;
    ##1 (!sn && !gn && wn)[*3] ##1 (sn && rsp_valid_out)
    ##1 !rsp_valid_out;
  endsequence
  sequence s_wr;
    ##1 (!sn && !on && wn) ##1 (!sn && !wn)[*2] ##1 (!sn && wn)
    ##1 (sn && on);
  endsequence
  property p_sec; secondary_select_hi_out == !sn; endproperty
  property p_rd; tk && !req_write_in |-> s_rd; endproperty
  property p_wr; tk && req_write_in |-> s_wr; endproperty
  property p_gate; !gn |-> wn; endproperty
  property p_addr; !sn && $past(!sn) |-> $stable(word_index_lines_out);
  endproperty
  property p_wfall; $fell(wn) |-> $past(!sn); endproperty
  property p_wrise; $rose(wn) |-> !sn ##1 sn; endproperty
  // Host drives the pins only while the memory's outputs are gated off
  property p_oe; !on |-> gn && !sn; endproperty
  a_sec: assert property (p_sec) else $error("second select wrong");
  a_rd: assert property (p_rd) else $error("read cycle shape");
  a_wr: assert property (p_wr) else $error("write cycle shape");
  a_gate: assert property (p_gate) else $error("strobe low in read");
  a_addr: assert property (p_addr) else $error("address moved");
  a_wfall: assert property (p_wfall) else $error("strobe before sel");
  a_wrise: assert property (p_wrise) else $error("sel before strobe");
  a_oe: assert property (p_oe) else $error("pin contention");
endmodule // asrc_host_checker

bind asrc_host asrc_host_checker i_asrc_host_checker (.*);

// ### verif/asrc_mem_model.sv
// Model: behavioural 32K-word asynchronous static memory
module asrc_mem_model
  import asrc_pkg::*;
#(parameter int ACC_NS = 12)
(
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              sel_n_in,
  input  wire logic              sec_in,
  input  wire logic              gate_n_in,
  input  wire logic              wr_n_in,
  input  wire logic [DATA_W-1:0] host_d_in,
  input  wire logic              host_oe_n_in,
  output logic      [DATA_W-1:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rd;
  event              wrote;
  wire sel = !sel_n_in && sec_in;
  wire wen = sel && !wr_n_in;
  wire drv = sel && !gate_n_in && wr_n_in;
  // Levels only; data settles late, at the full access time
  // Reread on an address change or after the store, so a read never races the write
  always @(addr_in or wrote)
    rd <= #(ACC_NS) mem[addr_in];
  always @(negedge wen) begin
    mem[addr_in] = host_d_in;
    -> wrote;
  end
  // Released pins flip so a stale value never reads as valid
  always @(host_d_in or rd or host_oe_n_in or drv)
    pin_out = (!host_oe_n_in && drv) ? 'x : !host_oe_n_in ? host_d_in
            : drv ? rd : ~pin_out;
endmodule // asrc_mem_model

// ### verif/asrc_host_test.sv
// Testbench: host controller against the memory model
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", n, e, s); end end
module asrc_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import asrc_pkg::*;
  logic              clock_in, arst_n_in, req_valid_in, req_write_in;
  logic [ADDR_W-1:0] req_addr_in, addr;
  logic [DATA_W-1:0] req_wdata_in, rdata, pins_in, pins_out;
  logic              ready, rsp_valid, sel_n, sec, gate_n, wr_n, oe_n;
  int                miscompares = 0;
  int                tests_run = 0;
  asrc_host i_asrc_host (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rdata), .word_index_lines_out(addr),
    .primary_select_n_out(sel_n), .secondary_select_hi_out(sec),
    .out_gate_n_out(gate_n), .write_strobe_n_out(wr_n),
    .bidir_data_pins_in(pins_in), .bidir_data_pins_out(pins_out),
    .bidir_data_pins_oe_n_out(oe_n));
  asrc_mem_model #(.ACC_NS(12)) i_asrc_mem_model (.addr_in(addr),
    .sel_n_in(sel_n), .sec_in(sec), .gate_n_in(gate_n), .wr_n_in(wr_n),
    .host_d_in(pins_out), .host_oe_n_in(oe_n), .pin_out(pins_in));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  task automatic issue(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output int n);
    n = 0;
    @(negedge clock_in);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge clock_in);
      n++;
    end
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while ((w ? ready : rsp_valid) !== 1'b1 && n < 20);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    issue(1'b1, a, d, n);
    `CHK("write busy", 7, n)
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int n;
    issue(1'b0, a, 9'h000, n);
    `CHK("read latency", 4, n)
    `CHK("read data", e, rdata)
    @(negedge clock_in);
    `CHK("rsp pulse", 1'b0, rsp_valid)
  endtask
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_idle();
    @(negedge clock_in);
    `CHK("idle pins", 5'h17, {sel_n, sec, gate_n, wr_n, oe_n})
    $display("t_idle done");
  endtask
  task automatic t_bounds();
    wr(15'h0000, 9'h1a5);
    wr(15'h7fff, 9'h05a);
    rd(15'h0000, 9'h1a5);
    rd(15'h7fff, 9'h05a);
    $display("t_bounds done");
  endtask
  task automatic t_over();
    wr(15'h0000, 9'h0ff);
    wr(15'h0000, 9'h100);
    rd(15'h0000, 9'h100);
    rd(15'h0000, 9'h100);
    rd(15'h7fff, 9'h05a);
    $display("t_over done");
  endtask
  // A request held while busy must not start a second write
  task automatic t_refuse();
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_write_in <= 1'b1;
    req_addr_in <= 15'h1234;
    req_wdata_in <= 9'h0aa;
    @(posedge clock_in);
    req_wdata_in <= 9'h155;
    repeat (3) @(posedge clock_in);
    req_valid_in <= 1'b0;
    rd(15'h1234, 9'h0aa);
    $display("t_refuse done");
  endtask
  task automatic wrap_up();
    $display("Counts: %0d run, %0d miscompares", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    arst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 15'h0000;
    req_wdata_in = 9'h000;
    repeat (5) @(posedge clock_in);
    arst_n_in <= 1'b1;
    t_idle();
    t_bounds();
    t_over();
    t_refuse();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clock_in);
    miscompares++;
    wrap_up();
  end
endmodule // asrc_host_test
